//--- hw/iar_pkg.sv
// Constants shared by the indirect address resolver and its users.
package iar_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Control word layout: bit 0 is the most significant bit of the 32-bit word.
    localparam int unsigned CW_TRAIL_POS = 27;    // Trail flag, word bit 4.
    localparam int unsigned CW_ABSENT_POS = 26;   // Absence flag, word bit 5.
    localparam int unsigned CW_REL_POS = 25;      // Relative flag, word bit 6.
    localparam int unsigned CW_IND_POS = 24;      // Indirect flag, word bit 7.
    localparam int unsigned CW_ADDR_W = 24;       // Address field, word bits 8-31.

    ////////////////////////////////////////////////////////////////////////////////
    // Current relocation register flags byte, bit 0 most significant.
    localparam int unsigned RR_INSTR_RELOC_POS = 4;   // instr_relocate_flag, bit 3.
    localparam int unsigned RR_DEST_IND_POS = 3;      // dest_indirect_flag, bit 4.
    localparam int unsigned RR_DEST_RELOC_POS = 2;    // Destination relocate, bit 5.
    localparam int unsigned RR_ORIGIN_IND_POS = 1;    // origin_indirect_flag, bit 6.
    localparam int unsigned RR_SRC_RELOC_POS = 0;     // source_relocate_flag, bit 7.

    ////////////////////////////////////////////////////////////////////////////////
    // Operand classes presented by the instruction pipeline.
    localparam logic [1:0] CLS_DIRECT = 2'h0;     // Load address, shift, I/O, branch.
    localparam logic [1:0] CLS_DEST = 2'h1;       // Destination operand.
    localparam logic [1:0] CLS_ORIGIN = 2'h2;     // Origin operand.
    localparam logic [1:0] CLS_BRLINK = 2'h3;     // indirect_branch_link_op.

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and protection constants.
    localparam logic [3:0] KEY_ALL = 4'hf;            // Storage key open to control words.
    localparam logic [3:0] KEY_ZERO = 4'h0;           // Master key.
    localparam logic [23:0] FAULT_LOC = 24'h00018c;   // Word receiving an absent word's address.
    localparam logic [3:0] BE_FLAGS = 4'h8;           // Lane of the flags byte.
    localparam logic [3:0] BE_ADDR = 4'h7;            // Lanes of bits 8-31.
    localparam int unsigned MAX_LEVELS = 8;           // Deepest chain allowed.

    ////////////////////////////////////////////////////////////////////////////////
    // Exception codes reported with a fault pulse.
    localparam logic [1:0] EXC_ABSENT = 2'h1;     // Indirect addressing exception.
    localparam logic [1:0] EXC_SPEC = 2'h2;       // Indirect address specification.
    localparam logic [1:0] EXC_PROT = 2'h3;       // Protection exception.

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers, byte addresses on the plain register port.
    localparam logic [7:0] REG_STATUS = 8'h00;    // Sticky events, write one to clear.
    localparam logic [7:0] REG_MASK = 8'h04;      // Interrupt mask, same layout.
    localparam logic [7:0] REG_CTRL = 8'h08;      // Bit 0 enables the resolver.
    localparam logic [7:0] REG_LAST = 8'h0c;      // Last final address.
    localparam logic [7:0] REG_CHAIN = 8'h10;     // Last control word address and depth.
    localparam int unsigned ST_DONE_POS = 0;      // Chain resolved.
    localparam int unsigned ST_ABSENT_POS = 1;    // Absent word met.
    localparam int unsigned ST_SPEC_POS = 2;      // Chain too deep.
    localparam int unsigned ST_PROT_POS = 3;      // Control word access refused.
    localparam int unsigned ST_W = 4;             // Status width.
    localparam logic [3:0] MASK_RESET = 4'h0;     // Mask after reset.
    localparam logic CTRL_EN_RESET = 1'b1;        // Enable after reset.

endpackage : iar_pkg

//--- hw/iar_resolver.sv
// Indirect address resolver: control word chain walker with register port.
//
// Behaviour
// R1: Flag bits 0-3 never affect anything.
// R2: Final word with trail set: clear, write back.
// R3: Absent word: exception, store its address low.
// R4: Relative flag adds relocation offset to field.
// R5: Indirect flag chooses next word or final.
// R6: Address field is bits 8-31 only.
// R7: Index added only after chain ends.
// R8: Read allowed by key F, zero, match, RP, escape.
// R9: Write allowed by key F, zero, match, escape.
// R10: Dest or origin flag selects first indirection.
// R11: Direct classes never indirect; branch-link always.
// R12: First address is displacement, base, offset.
// R13: Eighth word still indirect: specification exception.
// R14: First level relocation by instruction class flag.
// R15: Branch-link copies last relative flag out.
// R16: Final address gets normal protection only.
// R17: I/O channel requests never use indirection.
// R18: Control words fetched at word-aligned addresses.
// R19: Stall while storage access is outstanding.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module iar_resolver (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire logic req_io_i,
    input wire logic [1:0] req_class_i,
    input wire logic req_indexed_i,
    input wire logic [23:0] disp_base_i,
    input wire logic [23:0] index_val_i,
    input wire logic [7:0] reloc_flags_i,
    input wire logic [23:0] reloc_offset_i,
    input wire logic [3:0] psw_key_i,
    input wire logic protect_escape_i,
    output logic stall_o,
    output logic done_o,
    output logic [23:0] final_addr_o,
    output logic final_normal_prot_o,
    output logic instr_reloc_we_o,
    output logic instr_reloc_val_o,
    output logic exc_valid_o,
    output logic [1:0] exc_code_o,
    output logic prog_irq_req_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [23:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    output logic [3:0] mem_be_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic [3:0] mem_key_i,
    input wire logic mem_rp_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and storage.

    // Walker states.
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXAM, ST_TRAIL, ST_FAULT} iar_state_t;

    iar_state_t state_q;       // Current walker state.
    logic [31:0] cw_q;         // Last fetched control word.
    logic [23:0] cw_addr_q;    // Absolute address of that word.
    logic [3:0] level_q;       // Words fetched in this chain.
    logic indirect_branch_link_op_q;              // Chain belongs to a branch-link.
    logic indexed_q;           // Index is to be added at the end.
    logic [23:0] index_q;      // Index value caught at accept.
    logic [23:0] offset_q;     // Relocation offset caught at accept.
    logic [23:0] pend_addr_q;  // Final address waiting on a trail write.
    logic pend_rel_q;          // Relative flag of the final word.
    logic stall_q;             // Pipeline stall.
    logic done_q;              // Resolution pulse.
    logic [23:0] final_q;      // Resolved address.
    logic ri_we_q;             // Relocation register update pulse.
    logic ri_val_q;            // Value for instr_relocate_flag.
    logic exc_q;               // Exception pulse.
    logic [1:0] code_q;        // Exception code.
    logic pirq_q;              // Program exception request pulse.
    logic mreq_q;              // Storage request.
    logic mwe_q;               // Storage write.
    logic [23:0] maddr_q;      // Storage address.
    logic [31:0] mwdata_q;     // Storage write data.
    logic [3:0] mbe_q;         // Storage byte lanes.
    logic [3:0] status_q;      // Sticky events.
    logic [3:0] mask_q;        // Interrupt mask.
    logic ctrl_en_q;           // Resolver enable.
    logic [31:0] rdata_q;      // Register read data.
    logic irq_q;               // Interrupt level.

    ////////////////////////////////////////////////////////////////////////////////
    // Request classification and first address.

    // Only processor requests are served; channel addresses bypass this unit.
    wire accept = req_valid_i && !req_io_i && ctrl_en_q && (state_q == ST_IDLE); // R17
    wire sel_dest = (req_class_i == iar_pkg::CLS_DEST);
    wire sel_orig = (req_class_i == iar_pkg::CLS_ORIGIN);
    wire sel_indirect_branch_link_op = (req_class_i == iar_pkg::CLS_BRLINK);
    // Indirection comes from the relocation flags, or always for a branch-link.
    wire go_ind = (sel_dest && reloc_flags_i[iar_pkg::RR_DEST_IND_POS]) // R10
                || (sel_orig && reloc_flags_i[iar_pkg::RR_ORIGIN_IND_POS])
                || sel_indirect_branch_link_op; // R11
    // First level relocation flag by class.
    wire first_rel = (sel_dest && reloc_flags_i[iar_pkg::RR_DEST_RELOC_POS]) // R14
                   || (sel_orig && reloc_flags_i[iar_pkg::RR_SRC_RELOC_POS])
                   || (sel_indirect_branch_link_op && reloc_flags_i[iar_pkg::RR_INSTR_RELOC_POS]);
    wire [23:0] first_addr = disp_base_i + (first_rel ? reloc_offset_i : 24'h000000); // R12
    wire [23:0] direct_addr = first_addr + (req_indexed_i ? index_val_i : 24'h000000);
    wire [23:0] first_word = {first_addr[23:2], 2'h0}; // R18

    ////////////////////////////////////////////////////////////////////////////////
    // Control word decode; bits 0-3 of the word are never looked at.

    wire cw_trail = cw_q[iar_pkg::CW_TRAIL_POS]; // R1
    wire cw_absent = cw_q[iar_pkg::CW_ABSENT_POS];
    wire cw_rel = cw_q[iar_pkg::CW_REL_POS];
    wire cw_ind = cw_q[iar_pkg::CW_IND_POS];
    wire [23:0] cw_field = cw_q[iar_pkg::CW_ADDR_W-1:0]; // R6
    wire [23:0] cw_abs = cw_field + (cw_rel ? offset_q : 24'h000000); // R4
    wire [23:0] next_word = {cw_abs[23:2], 2'h0}; // R18
    wire [23:0] end_addr = pend_addr_q + (indexed_q ? index_q : 24'h000000); // R7
    wire [23:0] end_now = cw_abs + (indexed_q ? index_q : 24'h000000); // R7
    wire at_limit = (level_q == 4'(iar_pkg::MAX_LEVELS));
    wire [31:0] trail_data = {cw_q[31:28], 1'b0, cw_q[26:0]}; // R2

    ////////////////////////////////////////////////////////////////////////////////
    // Protection checks against the key of the word being read.

    wire key_open = (mem_key_i == iar_pkg::KEY_ALL);
    wire key_zero = (psw_key_i == iar_pkg::KEY_ZERO);
    wire key_match = (psw_key_i == mem_key_i);
    wire rd_ok = key_open || key_zero || key_match || !mem_rp_i || protect_escape_i; // R8
    wire wr_ok = key_open || key_zero || key_match || protect_escape_i; // R9

    wire ack_fetch = (state_q == ST_FETCH) && mem_ack_i; // R19
    wire exam = (state_q == ST_EXAM);
    wire ex_absent = exam && cw_absent; // R3
    wire ex_final = exam && !cw_absent && !cw_ind;
    wire ex_chain = exam && !cw_absent && cw_ind; // R5
    wire trail_go = ex_final && cw_trail;
    wire finish = (ex_final && !cw_trail)
                || ((state_q == ST_TRAIL) && mem_ack_i);
    wire [23:0] done_addr = (state_q == ST_TRAIL) ? end_addr : end_now;
    wire done_rel = (state_q == ST_TRAIL) ? pend_rel_q : cw_rel;

    ////////////////////////////////////////////////////////////////////////////////
    // Walker state machine.

    // Each storage access holds the walker until its acknowledge.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // Indirect requests start a fetch; others finish at once.
                    if (accept && go_ind)
                    begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    // Flags are examined only once read data is back.
                    if (mem_ack_i)
                    begin
                        state_q <= rd_ok ? ST_EXAM : ST_IDLE; // R19
                    end
                end
                ST_EXAM:
                begin
                    // One step along the chain per examined word.
                    if (cw_absent)
                    begin
                        state_q <= ST_FAULT;
                    end
                    else if (cw_ind)
                    begin
                        state_q <= at_limit ? ST_IDLE : ST_FETCH; // R13
                    end
                    else if (cw_trail && wr_ok)
                    begin
                        state_q <= ST_TRAIL;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    // Trail and fault writes end on their acknowledge.
                    if (mem_ack_i)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Chain context captured at accept and updated per fetched word.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cw_q <= 32'h00000000;
            cw_addr_q <= 24'h000000;
            level_q <= 4'h0;
            indirect_branch_link_op_q <= 1'b0;
            indexed_q <= 1'b0;
            index_q <= 24'h000000;
            offset_q <= 24'h000000;
            pend_addr_q <= 24'h000000;
            pend_rel_q <= 1'b0;
        end
        else
        begin
            if (accept)
            begin
                cw_addr_q <= first_word;
                level_q <= 4'h1;
                indirect_branch_link_op_q <= sel_indirect_branch_link_op;
                indexed_q <= req_indexed_i;
                index_q <= index_val_i;
                offset_q <= reloc_offset_i;
            end
            if (ack_fetch)
            begin
                cw_q <= mem_rdata_i;
            end
            if (ex_chain && !at_limit)
            begin
                cw_addr_q <= next_word;
                level_q <= level_q + 4'h1;
            end
            if (trail_go)
            begin
                pend_addr_q <= cw_abs;
                pend_rel_q <= cw_rel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage port; the request is held until the acknowledge.

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            mreq_q <= 1'b0;
            mwe_q <= 1'b0;
            maddr_q <= 24'h000000;
            mwdata_q <= 32'h00000000;
            mbe_q <= 4'h0;
        end
        else if (accept && go_ind)
        begin
            mreq_q <= 1'b1; // R12
            mwe_q <= 1'b0;
            maddr_q <= first_word;
        end
        else if (ex_chain && !at_limit)
        begin
            mreq_q <= 1'b1; // R5
            mwe_q <= 1'b0;
            maddr_q <= next_word;
        end
        else if (trail_go && wr_ok)
        begin
            mreq_q <= 1'b1; // R2
            mwe_q <= 1'b1;
            maddr_q <= cw_addr_q;
            mwdata_q <= trail_data;
            mbe_q <= iar_pkg::BE_FLAGS;
        end
        else if (ex_absent)
        begin
            mreq_q <= 1'b1; // R3
            mwe_q <= 1'b1;
            maddr_q <= iar_pkg::FAULT_LOC;
            mwdata_q <= {8'h00, cw_addr_q};
            mbe_q <= iar_pkg::BE_ADDR;
        end
        else if (mem_ack_i)
        begin
            mreq_q <= 1'b0;
            mwe_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Results and exceptions toward the pipeline.

    wire fault_done = (state_q == ST_FAULT) && mem_ack_i;
    wire spec_hit = ex_chain && at_limit; // R13
    wire prot_hit = (ack_fetch && !rd_ok) || (trail_go && !wr_ok); // R8 R9
    wire direct_done = accept && !go_ind; // R11

    // Pulses last one cycle; stall covers every cycle of a chain.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            stall_q <= 1'b0;
            done_q <= 1'b0;
            final_q <= 24'h000000;
            ri_we_q <= 1'b0;
            ri_val_q <= 1'b0;
            exc_q <= 1'b0;
            code_q <= 2'h0;
            pirq_q <= 1'b0;
        end
        else
        begin
            stall_q <= (accept && go_ind) || (stall_q && !(finish || spec_hit
                       || prot_hit || fault_done)); // R19
            done_q <= finish || direct_done;
            ri_we_q <= finish && indirect_branch_link_op_q; // R15
            exc_q <= spec_hit || prot_hit || fault_done;
            pirq_q <= spec_hit || prot_hit || fault_done;
            if (finish)
            begin
                final_q <= done_addr; // R7
                ri_val_q <= done_rel; // R15
            end
            else if (direct_done)
            begin
                final_q <= direct_addr;
            end
            if (fault_done)
            begin
                code_q <= iar_pkg::EXC_ABSENT; // R3
            end
            else if (spec_hit)
            begin
                code_q <= iar_pkg::EXC_SPEC; // R13
            end
            else if (prot_hit)
            begin
                code_q <= iar_pkg::EXC_PROT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port and interrupt.

    wire [3:0] events = {prot_hit, spec_hit, fault_done, finish};
    wire [3:0] w1c = (reg_we_i && reg_addr_i == iar_pkg::REG_STATUS) ? reg_wdata_i[3:0] : 4'h0;
    wire [3:0] status_d = (status_q & ~w1c) | events; // Set wins over clear.
    wire [31:0] rd_mux = (reg_addr_i == iar_pkg::REG_STATUS) ? {28'h0, status_q}
                       : (reg_addr_i == iar_pkg::REG_MASK) ? {28'h0, mask_q}
                       : (reg_addr_i == iar_pkg::REG_CTRL) ? {31'h0, ctrl_en_q}
                       : (reg_addr_i == iar_pkg::REG_LAST) ? {8'h00, final_q}
                       : (reg_addr_i == iar_pkg::REG_CHAIN) ? {level_q, 4'h0, cw_addr_q}
                       : 32'h00000000;

    // Registers, read data one cycle after the strobe, and the interrupt level.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            status_q <= 4'h0;
            mask_q <= iar_pkg::MASK_RESET;
            ctrl_en_q <= iar_pkg::CTRL_EN_RESET;
            rdata_q <= 32'h00000000;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
            rdata_q <= reg_re_i ? rd_mux : 32'h00000000;
            if (reg_we_i && reg_addr_i == iar_pkg::REG_MASK)
            begin
                mask_q <= reg_wdata_i[3:0];
            end
            if (reg_we_i && reg_addr_i == iar_pkg::REG_CTRL)
            begin
                ctrl_en_q <= reg_wdata_i[0];
            end
        end
    end

    assign stall_o = stall_q;
    assign done_o = done_q;
    assign final_addr_o = final_q;
    assign final_normal_prot_o = done_q; // R16
    assign instr_reloc_we_o = ri_we_q;
    assign instr_reloc_val_o = ri_val_q;
    assign exc_valid_o = exc_q;
    assign exc_code_o = code_q;
    assign prog_irq_req_o = pirq_q;
    assign mem_req_o = mreq_q;
    assign mem_we_o = mwe_q;
    assign mem_addr_o = maddr_q;
    assign mem_wdata_o = mwdata_q;
    assign mem_be_o = mbe_q;
    assign reg_rdata_o = rdata_q;
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence final_trail_s;
        ex_final && cw_trail && wr_ok;
    endsequence

    trail_write_a: assert property (final_trail_s |=> mem_we_o && mem_be_o == 4'h8 // R2
        && !mem_wdata_o[27] && mem_addr_o == $past(cw_addr_q))
        else $error("trail write-back wrong");
    absent_store_a: assert property (ex_absent |=> mem_addr_o == 24'h00018c // R3
        && mem_wdata_o[23:0] == $past(cw_addr_q) && mem_be_o == 4'h7)
        else $error("absent address not stored");
    chain_fetch_a: assert property (ex_chain && !at_limit |=> mem_req_o && !mem_we_o // R5
        && mem_addr_o == {$past(cw_abs[23:2]), 2'h0})
        else $error("next word not fetched");
    depth_limit_a: assert property (ex_chain && level_q == 4'h8 |=> exc_valid_o // R13
        && exc_code_o == 2'h2 && prog_irq_req_o)
        else $error("chain depth not limited");
    read_prot_a: assert property (ack_fetch && !rd_ok |=> exc_code_o == 2'h3 // R8
        && !mem_req_o ##1 !stall_o)
        else $error("refused read not flagged");
    write_prot_a: assert property (trail_go && !wr_ok |=> !mem_req_o && exc_valid_o) // R9
        else $error("refused write issued");
    final_index_a: assert property (ex_final && !cw_trail |=> done_o // R7
        && final_addr_o == $past(end_now))
        else $error("final address wrong");
    indirect_branch_link_op_copy_a: assert property (finish && indirect_branch_link_op_q |=> instr_reloc_we_o // R15
        && instr_reloc_val_o == $past(done_rel))
        else $error("relative flag not copied");
    direct_path_a: assert property (direct_done |=> done_o && !mem_req_o // R11
        && final_addr_o == $past(direct_addr))
        else $error("direct request fetched");
    io_bypass_a: assert property (req_valid_i && req_io_i && state_q == ST_IDLE // R17
        |=> !mem_req_o && !done_o)
        else $error("channel request served");
    stall_cover_a: assert property (mem_req_o |-> stall_o) // R19
        else $error("access without stall");
    first_word_a: assert property (accept && go_ind |=> mem_req_o // R12
        && mem_addr_o[1:0] == 2'h0 && mem_addr_o == $past(first_word))
        else $error("first fetch address wrong");

endmodule : iar_resolver

//--- test/iar_store_model.sv
// Storage model that answers resolver word accesses after a chosen wait.
`timescale 1ns/1ps
module iar_store_model (
    input wire logic core_clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [23:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [3:0] mem_be_i,
    input wire logic [1:0] slow_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [31:0] mem [0:127];
    logic [1:0] wait_q = 2'h0;
    // Answers after slow_i idle cycles; the data bus shows junk between answers.
    always_ff @(posedge core_clk_i)
    begin
        mem_ack_o <= 1'h0;
        mem_rdata_o <= ~mem_rdata_o;
        wait_q <= (mem_req_i && !mem_ack_o) ? wait_q + 2'h1 : 2'h0;
        if (mem_req_i && !mem_ack_o && wait_q == slow_i)
        begin
            mem_ack_o <= 1'h1;
            mem_rdata_o <= mem[mem_addr_i[8:2]];
            for (int b = 0; b < 4; b++)
                if (mem_we_i && mem_be_i[b])
                    mem[mem_addr_i[8:2]][8*b+:8] <= mem_wdata_i[8*b+:8];
        end
    end
endmodule : iar_store_model

//--- test/indirect_address_resolver_test.sv
// Self-checking bench for the indirect address resolver.
`timescale 1ns/1ps
module indirect_address_resolver_test;
    logic core_clk_i = 1'h0, reset_i = 1'h1, req_valid_i = 1'h0, req_io_i = 1'h0;
    logic req_indexed_i = 1'h1, protect_escape_i = 1'h0, mem_rp_i = 1'h0, mem_ack_i;
    logic reg_we_i = 1'h0, reg_re_i = 1'h0, stall_o, done_o, final_normal_prot_o;
    logic instr_reloc_we_o, instr_reloc_val_o, exc_valid_o, prog_irq_req_o, mem_req_o;
    logic mem_we_o, irq_o;
    logic [1:0] req_class_i = 2'h0, slow = 2'h0, exc_code_o;
    logic [3:0] psw_key_i = 4'h0, mem_key_i = 4'h0, mem_be_o;
    logic [7:0] reloc_flags_i = 8'h08, reg_addr_i = 8'h0;
    logic [23:0] disp_base_i = 24'h10, index_val_i = 24'h4, reloc_offset_i = 24'h0;
    logic [23:0] final_addr_o, mem_addr_o;
    logic [31:0] mem_rdata_i, reg_wdata_i = 32'h0, reg_rdata_o, mem_wdata_o;
    int fails = 0, tests_run = 0;
    iar_resolver iar_resolver_inst (.*);
    iar_store_model iar_store_model_inst (.core_clk_i, .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_be_i(mem_be_o), .slow_i(slow), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    // The clock toggles every half period of 12.5 ns.
    always #12.5 core_clk_i = ~core_clk_i;
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : check
    // Steps to the next falling edge and gives up once the bound is spent.
    task automatic tick(input int n);
        @(negedge core_clk_i);
        if (n > 40)
        begin
            fails++;
            end_of_test();
        end
    endtask : tick
    // One register access; a read is judged in the cycle after its strobe.
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= wr;
        reg_re_i <= !wr;
        @(posedge core_clk_i);
        reg_we_i <= 1'h0;
        reg_re_i <= 1'h0;
        @(negedge core_clk_i);
        if (!wr) check(reg_rdata_o, d);
    endtask : reg_op
    // One request; judges exception, code, done and final address together.
    task automatic request(input logic [1:0] cls, input logic [29:0] want);
        @(posedge core_clk_i);
        req_class_i <= cls;
        req_valid_i <= 1'h1;
        @(posedge core_clk_i);
        req_valid_i <= 1'h0;
        for (int n = 0; n == 0 || !(done_o || exc_valid_o); n++) tick(n);
        check({instr_reloc_we_o, final_normal_prot_o, exc_valid_o, exc_code_o, done_o,
            final_addr_o}, want);
        for (int n = 0; stall_o; n++) tick(n);
    endtask : request
    initial
    begin
        iar_store_model_inst.mem[4] = 32'h01000020;
        iar_store_model_inst.mem[8] = 32'hf8000100;
        iar_store_model_inst.mem[12] = 32'h04000000;
        iar_store_model_inst.mem[20] = 32'h02000100;
        iar_store_model_inst.mem[24] = 32'h01000060;
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'h0;
        reg_op(1'h0, iar_pkg::REG_MASK, 32'h0);
        reg_op(1'h0, iar_pkg::REG_CTRL, 32'h1);
        reg_op(1'h0, 8'h14, 32'h0);
        request(iar_pkg::CLS_DEST, 30'h11000104);
        check(iar_store_model_inst.mem[8], 32'hf0000100);
        @(posedge core_clk_i);
        disp_base_i <= 24'h30;
        slow <= 2'h2;
        request(iar_pkg::CLS_DEST, 30'h0a000104);
        check({8'h0, iar_store_model_inst.mem[99][23:0]}, 32'h30);
        @(posedge core_clk_i);
        disp_base_i <= 24'h10;
        psw_key_i <= 4'h3;
        mem_key_i <= 4'h5;
        mem_rp_i <= 1'h1;
        request(iar_pkg::CLS_DEST, 30'h0e000104);
        request(iar_pkg::CLS_DIRECT, 30'h17000014);
        @(posedge core_clk_i);
        reloc_flags_i <= 8'h10;
        reloc_offset_i <= 24'h40;
        mem_rp_i <= 1'h0;
        request(iar_pkg::CLS_BRLINK, 30'h37000144);
        check(instr_reloc_val_o, 1'h1);
        @(posedge core_clk_i);
        reloc_flags_i <= 8'h02;
        disp_base_i <= 24'h60;
        slow <= 2'h0;
        request(iar_pkg::CLS_ORIGIN, 30'h0c000144);
        reg_op(1'h0, iar_pkg::REG_STATUS, 32'hf);
        check(irq_o, 1'h0);
        reg_op(1'h1, iar_pkg::REG_MASK, 32'h2);
        @(negedge core_clk_i);
        check(irq_o, 1'h1);
        reg_op(1'h1, iar_pkg::REG_STATUS, 32'h2);
        check(irq_o, 1'h0);
        reg_op(1'h0, iar_pkg::REG_STATUS, 32'hd);
        end_of_test();
    end
endmodule : indirect_address_resolver_test
